//--- bench/interprocessor_direct_control_tb.sv
// Purpose: self-checking bench of the direct-control unit
// Assumes: APB slave answers by pready, peer lines from peer_model
// Notes: target is element 2 for the command table, sender is element 1 for receive, element 2 for the excluded-sender cases
`timescale 1ns/1ps
`default_nettype none
module interprocessor_direct_control_tb import dctl_pkg::*;;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r;
	logic pready, pslverr, e, hold_out, send_go = 0, instr_end = 0, io_instr_end = 0;
	logic [1:0] send_s = '0;
	line_t send_ln = '0;
	logic [3:0] hold_in = '0, rx_hold;
	logic [3:0][7:0] byte_in = '0, rx_byte;
	line_t [3:0] rx_line, tx_line;
	logic [7:0] direct_out;
	ce_state_t ce_state;
	io_state_t io_state;
	logic start_fetch, logout_req, ce_reset, ext_take, io_fetch, io_take, io_timer_en;
	logic io_logout_req;
	logic [23:0] fetch_addr, logout_addr;
	logic [3:0] io_logout_src;
	int n_errors = 0, check_count = 0, cyc = 0, n;
	// Command code beside the one line it should raise
	localparam logic [13:0] ROWS [8] = '{14'h0004, 14'h0600, 14'h0900, 14'h0C80,
		14'h1040, 14'h1420, 14'h1810, 14'h1C08};
	always #20 pclk = ~pclk;
	direct_control i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_line(rx_line), .rx_hold(rx_hold), .rx_byte(rx_byte),
		.tx_line(tx_line), .direct_out(direct_out), .hold_out(hold_out),
		.instr_end(instr_end), .core_wait(1'b0), .check_stop(1'b0),
		.io_instr_end(io_instr_end), .ce_state(ce_state), .io_state(io_state),
		.start_fetch(start_fetch), .fetch_addr(fetch_addr), .logout_req(logout_req),
		.logout_addr(logout_addr), .ce_reset(ce_reset), .ext_take(ext_take),
		.io_fetch(io_fetch), .io_take(io_take), .io_timer_en(io_timer_en),
		.io_logout_req(io_logout_req), .io_logout_src(io_logout_src));
	peer_model i_peer (.pclk(pclk), .presetn(presetn), .send_s(send_s), .send_ln(send_ln),
		.send_go(send_go), .hold_in(hold_in), .byte_in(byte_in), .rx_line(rx_line),
		.rx_hold(rx_hold), .rx_byte(rx_byte));
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		instr_end <= (cyc[1:0] == 2'h0);
		io_instr_end <= (cyc[1:0] == 2'h2);
		// Ceiling well above the several hundred cycles the run needs
		if (cyc == 20000) begin
			n_errors = n_errors + 1;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("errors=%0d checks=%0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask
	// Starts one edge after the caller so a release and a new setup never share a step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		logic rdy;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Sampled mid-cycle so a stall ending on the edge is not taken as an answer
		do begin
			@(negedge pclk);
			rdy = pready;
			r = prdata;
			e = pslverr;
			@(posedge pclk);
		end while (rdy !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic ev(input logic [1:0] s, input line_t l);
		@(posedge pclk);
		send_s <= s;
		send_ln <= l;
		send_go <= 1'b1;
		@(posedge pclk);
		send_go <= 1'b0;
		n = 0;
		repeat (14) begin
			@(posedge pclk);
			#1;
			n += start_fetch + logout_req + io_logout_req + io_fetch + ce_reset;
		end
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		chk(ce_state, CE_STOP);
		apb(1'b1, OFF_CTRL, 32'h0000_3111);
		apb(1'b1, OFF_SAVE, 32'h0000_1230);
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, OFF_WRD, {16'h0, 8'hC0 + 8'(i), ROWS[i][13:10], 4'h4});
			@(posedge pclk);
			#1;
			chk(tx_line[1], ROWS[i][9:0]);
			if (i == 0) chk(hold_out, 1'b1);
		end
		chk(direct_out, 8'hC0);
		apb(1'b1, OFF_WRD, 32'h0000_001C);
		apb(1'b0, OFF_STAT, '0);
		chk(r[0], 1'b1);
		apb(1'b1, OFF_STAT, 32'h0000_1FFF);
		apb(1'b1, OFF_WRD, 32'h0000_0088);
		apb(1'b0, OFF_STAT, '0);
		chk(r[0], 1'b1);
		apb(1'b1, OFF_CTRL, 32'h0000_2111);
		apb(1'b1, OFF_WRD, 32'h0000_0018);
		apb(1'b0, OFF_STAT, '0);
		chk(r[1], 1'b1);
		chk(tx_line[0], '0);
		apb(1'b1, OFF_CTRL, 32'h0000_3111);
		apb(1'b0, 12'h020, '0);
		chk(e, 1'b1);
		ev(2'd0, 10'h200);
		chk(n, 1);
		chk(fetch_addr, 24'h001230);
		chk(ce_state, CE_OPER);
		ev(2'd1, 10'h200);
		chk(n, 0);
		ev(2'd0, 10'h100);
		chk(n, 1);
		chk(logout_addr, 24'h001230);
		ev(2'd0, 10'h080);
		chk(n, 1);
		chk(io_logout_src, 4'h1);
		ev(2'd1, 10'h080);
		chk(n, 0);
		ev(2'd0, 10'h040);
		chk(ce_state, CE_STOP);
		chk(n, 1);
		ev(2'd0, 10'h020);
		chk(io_state, IO_RUN);
		chk(n, 1);
		chk(io_timer_en, 1'b1);
		ev(2'd0, 10'h010);
		chk(io_state, IO_STOP);
		chk(io_timer_en, 1'b0);
		ev(2'd1, 10'h020);
		chk(io_state, IO_STOP);
		ev(2'd0, 10'h008);
		apb(1'b0, OFF_STAT, '0);
		chk(r[14], 1'b1);
		apb(1'b1, OFF_STAT, 32'h0000_1FFF);
		ev(2'd1, 10'h004);
		apb(1'b0, OFF_STAT, '0);
		chk(r[8:5], 4'h0);
		ev(2'd0, 10'h004);
		apb(1'b0, OFF_STAT, '0);
		chk(|r[8:5], 1'b1);
		byte_in[0] <= 8'h5A;
		apb(1'b1, OFF_RDD, 32'h0000_0008);
		for (int k = 0; k < 40 && r[4] !== 1'b1; k++) apb(1'b0, OFF_STAT, '0);
		chk(r[4], 1'b1);
		apb(1'b0, OFF_RDD, '0);
		chk(r[7:0], 8'h5A);
		hold_in[0] <= 1'b1;
		apb(1'b1, OFF_STAT, 32'h0000_1FFF);
		apb(1'b1, OFF_RDD, 32'h0000_0008);
		repeat (130) @(posedge pclk);
		apb(1'b0, OFF_STAT, '0);
		chk(r[3:2], 2'h3);
		report_and_stop();
	end
endmodule
`default_nettype wire

//--- bench/peer_model.sv
// Purpose: far-side elements driving command lines, hold-in and direct-in bytes
// Assumes: one sender raises one line per request, held several cycles
// Notes: a byte under active hold-in toggles every cycle so it is never static
`timescale 1ns/1ps
`default_nettype none
module peer_model import dctl_pkg::*; (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [1:0]       send_s,
	input  wire line_t            send_ln,
	input  wire logic             send_go,
	input  wire logic [3:0]       hold_in,
	input  wire logic [3:0][7:0]  byte_in,
	output line_t     [3:0]       rx_line,
	output logic      [3:0]       rx_hold,
	output logic      [3:0][7:0]  rx_byte
);
	int cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_line <= '0;
			cnt <= 0;
		end else if (send_go) begin
			rx_line[send_s] <= send_ln;
			cnt <= 6;
		end else if (cnt == 1) begin
			rx_line <= '0;
			cnt <= 0;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end
	always_ff @(posedge pclk) begin
		rx_hold <= hold_in;
		for (int i = 0; i < 4; i++) begin
			rx_byte[i] <= hold_in[i] ? ~rx_byte[i] : byte_in[i];
		end
	end
endmodule
`default_nettype wire

//--- rtl/dctl_pkg.sv
// Purpose: shared types and constants of the direct-control unit
// Assumes: pclk at 25 MHz, registers reached over APB
// Notes: element index 0 stands for element 1 (select bit 12)
`default_nettype none
package dctl_pkg;
	localparam int CLK_PERIOD_NS = 40;
	localparam int HOLD_TMO_NS   = 4000;
	localparam int HOLD_TMO_CYC  = (HOLD_TMO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LINE_CYC      = 4;

	localparam logic [11:0] OFF_CTRL  = 12'h000;
	localparam logic [11:0] OFF_SAVE  = 12'h004;
	localparam logic [11:0] OFF_WRD   = 12'h008;
	localparam logic [11:0] OFF_RDD   = 12'h00C;
	localparam logic [11:0] OFF_STAT  = 12'h010;
	localparam logic [11:0] OFF_IOWRD = 12'h014;
	localparam logic [23:0] SAVE_RST  = 24'h000000;

	typedef enum logic [3:0] {
		CMD_DATA      = 4'h0,
		CMD_START     = 4'h1,
		CMD_LOGOUT    = 4'h2,
		CMD_IO_LOGOUT = 4'h3,
		CMD_STOP      = 4'h4,
		CMD_IO_START  = 4'h5,
		CMD_IO_STOP   = 4'h6,
		CMD_IO_INTR   = 4'h7,
		CMD_IO_WRD    = 4'h8
	} cmd_t;

	typedef enum logic [1:0] {
		CE_STOP = 2'h0, CE_OPER = 2'h1, CE_WAIT = 2'h3, CE_CHKSTOP = 2'h2
	} ce_state_t;

	typedef enum logic [1:0] {
		IO_STOP = 2'h0, IO_RUN = 2'h1, IO_WAIT = 2'h3
	} io_state_t;

	typedef struct packed {
		logic ext_start;
		logic logout;
		logic io_logout;
		logic ext_stop;
		logic io_start;
		logic io_stop;
		logic io_intr;
		logic data_intr;
		logic rdd_ack;
		logic proc_intr;
	} line_t;

	typedef struct packed {
		logic [13:0] rsvd;
		logic [1:0]  ctl_ce;
		logic        io_wait;
		logic        io_mask7;
		logic        ce_mask7;
		logic        supervisor;
		logic [3:0]  io_comm;
		logic [3:0]  data_comm;
		logic [3:0]  listen_cfg;
	} ctrl_t;

	typedef struct packed {
		logic [12:0] rsvd;
		io_state_t   io_st;
		ce_state_t   ce_st;
		logic        io_pend;
		logic        rdd_busy;
		logic [3:0]  processor_intr_reg;
		logic [3:0]  ext_intr;
		logic        rdd_done;
		logic        tmo_id;
		logic        mchk;
		logic        priv;
		logic        spec;
	} stat_t;

	localparam ctrl_t CTRL_RST = '0;
endpackage
`default_nettype wire

//--- rtl/direct_control.sv
// Purpose: direct-control unit of one computing element with its I/O processor side
// Assumes: peer lines are asynchronous and held for several pclk cycles
// Notes: register map and field layout are in dctl_pkg
// Operation
// - External start needs exactly one select bit, else specification check.
// - Receiver accepts external start only with listen bit for sender set.
// - Accepted start loads status word from save area location zero.
// - Logout command with multi-bit select gives specification check.
// - Logout honoured only with listen bit; uses own save area base.
// - I/O logout needs one selected I/O element, else specification check.
// - I/O side honours logout only with communication bit for requester.
// - Accepted stop ends instruction, goes stopped, resets, drops pending interrupts.
// - External stop needs listen bit and a single selected element.
// - Processor stop at instruction end; keeps pending interrupt, timer frozen.
// - Processor start leaves stop at once; wait if bit 14, else run.
// - Processor interrupt taken if bit 7 and running or waiting, else pending.
// - Processor stop, start, interrupt need communication bit for requester.
// - Read direct stores one byte, only while hold-in is inactive.
// - Hold-in active over 4 us ends read with machine check, bit 29.
// - Accepted byte sets bit in sender's external interrupt register.
// - I/O write direct code 1000 raises processor interruption line.
// - That request needs communication bit; taken only with bit 7 on.
// - Data communication sets external interrupt; taken at instruction end if bit 7.
// - Excluded sender's data write and read direct are fully ignored.
// - Data communication to I/O side has no effect.
// - Write and read direct only issue in supervisor state.
// - Command code in bits 8-11; leading one is invalid.
// - Bits 12-15 select elements 1 to 4 one-hot.
// - Data byte drives static outputs until next write direct; write directs with other command codes leave it unchanged.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module direct_control import dctl_pkg::*; (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire line_t [3:0]       rx_line,
	input  wire logic  [3:0]       rx_hold,
	input  wire logic  [3:0][7:0]  rx_byte,
	output line_t      [3:0]       tx_line,
	output logic       [7:0]       direct_out,
	output logic                   hold_out,
	input  wire logic              instr_end,
	input  wire logic              core_wait,
	input  wire logic              check_stop,
	input  wire logic              io_instr_end,
	output ce_state_t              ce_state,
	output io_state_t              io_state,
	output logic                   start_fetch,
	output logic       [23:0]      fetch_addr,
	output logic                   logout_req,
	output logic       [23:0]      logout_addr,
	output logic                   ce_reset,
	output logic                   ext_take,
	output logic                   io_fetch,
	output logic                   io_take,
	output logic                   io_timer_en,
	output logic                   io_logout_req,
	output logic       [3:0]       io_logout_src
);
	ctrl_t             ctrl_q;
	logic [23:0]       save_q;
	stat_t             stat_q;
	logic [31:0]       rdata_q;
	line_t [3:0]       ln_m_q, ln_s_q, ln_p_q, rise, tx_q;
	logic  [3:0]       hold_m_q, hold_s_q;
	logic  [3:0][7:0]  byte_m_q, byte_s_q;
	logic  [3:0]       g_start, g_logout, g_stop, g_iolog, g_iostart, g_iostop, g_iointr;
	logic  [3:0]       g_ext, g_pir;
	logic  [3:0]       a_start_q, a_logout_q, a_stop_q, a_iolog_q, a_iostart_q;
	logic  [3:0]       a_iostop_q, a_iointr_q, a_ext_q, a_pir_q;
	logic  [3:0]       tgt, tx_nz;
	logic  [1:0]       sel_idx, rd_src_q;
	logic  [2:0]       line_cnt_q;
	logic  [7:0]       rd_cnt_q, rd_byte_q, dout_q;
	logic              hold_q, rd_busy_q, stop_pend_q, io_stop_pend_q;
	logic              start_q, logout_q, reset_q, ext_take_q, io_fetch_q, io_take_q;
	logic              io_log_q;
	logic  [23:0]      fetch_q, logout_addr_q;
	ce_state_t         ce_state_q;
	io_state_t         io_state_q;
	cmd_t              cmd;
	line_t             pulse;
	logic              acc, wr, is_line, line_free, mapped, bad_cmd;
	logic              wr_wrd, wr_io, wrd_go, io_go, wr_rdd, rdd_go, ack_go, tmo_hit;

	assign cmd       = cmd_t'(pwdata[7:4]);
	assign tgt       = {pwdata[0], pwdata[1], pwdata[2], pwdata[3]};
	assign line_free = (line_cnt_q == 3'h0);
	assign is_line   = (paddr == OFF_WRD) || (paddr == OFF_IOWRD);
	assign mapped    = is_line || paddr == OFF_CTRL || paddr == OFF_SAVE
		|| paddr == OFF_RDD || paddr == OFF_STAT;
	// Stall instead of dropping a command while the lines are still held
	assign pready  = !(psel && penable && pwrite
		&& ((is_line && !line_free) || (paddr == OFF_RDD && rd_busy_q)));
	assign pslverr = psel && penable && !mapped;
	assign prdata  = rdata_q;
	assign acc     = psel && penable && pready && mapped;
	assign wr      = acc && pwrite;
	assign wr_wrd  = wr && paddr == OFF_WRD;
	assign wr_io   = wr && paddr == OFF_IOWRD;
	assign wr_rdd  = wr && paddr == OFF_RDD;
	assign bad_cmd = pwdata[7] || (cmd != CMD_DATA && !$onehot(tgt));
	assign wrd_go  = wr_wrd && ctrl_q.supervisor && !bad_cmd;
	assign io_go   = wr_io && cmd == CMD_IO_WRD && ctrl_q.io_comm[ctrl_q.ctl_ce];
	assign rdd_go  = wr_rdd && ctrl_q.supervisor && $onehot(tgt);
	assign ack_go  = rd_busy_q && !hold_s_q[rd_src_q] && line_free && !wr_wrd && !wr_io;
	assign tmo_hit = rd_busy_q && hold_s_q[rd_src_q] && rd_cnt_q == 8'(HOLD_TMO_CYC);
	assign rise    = ln_s_q & ~ln_p_q;

	always_comb begin
		pulse = '0;
		case (cmd)
			CMD_DATA:      pulse.data_intr = 1'b1;
			CMD_START:     pulse.ext_start = 1'b1;
			CMD_LOGOUT:    pulse.logout    = 1'b1;
			CMD_IO_LOGOUT: pulse.io_logout = 1'b1;
			CMD_STOP:      pulse.ext_stop  = 1'b1;
			CMD_IO_START:  pulse.io_start  = 1'b1;
			CMD_IO_STOP:   pulse.io_stop   = 1'b1;
			CMD_IO_INTR:   pulse.io_intr   = 1'b1;
			default:       pulse = '0;
		endcase
	end

	always_comb begin
		sel_idx = 2'h0;
		for (int i = 0; i < 4; i++) begin
			if (tgt[i]) begin
				sel_idx = 2'(i);
			end
		end
	end

	// Gating per sender, except proc_intr which is taken ungated; the I/O side has no data-byte input at all
	for (genvar s = 0; s < 4; s++) begin : g_rx
		assign g_start[s]   = rise[s].ext_start & ctrl_q.listen_cfg[s];
		assign g_logout[s]  = rise[s].logout & ctrl_q.listen_cfg[s];
		assign g_stop[s]    = rise[s].ext_stop & ctrl_q.listen_cfg[s];
		assign g_iolog[s]   = rise[s].io_logout & ctrl_q.io_comm[s];
		assign g_iostart[s] = rise[s].io_start & ctrl_q.io_comm[s];
		assign g_iostop[s]  = rise[s].io_stop & ctrl_q.io_comm[s];
		assign g_iointr[s]  = rise[s].io_intr & ctrl_q.io_comm[s];
		assign g_ext[s]     = (rise[s].data_intr | rise[s].rdd_ack) & ctrl_q.data_comm[s];
		assign g_pir[s]     = rise[s].proc_intr;
		assign tx_nz[s]     = |tx_q[s];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ln_m_q   <= '0;
			ln_s_q   <= '0;
			ln_p_q   <= '0;
			hold_m_q <= 4'h0;
			hold_s_q <= 4'h0;
			byte_m_q <= '0;
			byte_s_q <= '0;
		end else begin
			ln_m_q   <= rx_line;
			ln_s_q   <= ln_m_q;
			ln_p_q   <= ln_s_q;
			hold_m_q <= rx_hold;
			hold_s_q <= hold_m_q;
			byte_m_q <= rx_byte;
			byte_s_q <= byte_m_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_start_q   <= 4'h0;
			a_logout_q  <= 4'h0;
			a_stop_q    <= 4'h0;
			a_iolog_q   <= 4'h0;
			a_iostart_q <= 4'h0;
			a_iostop_q  <= 4'h0;
			a_iointr_q  <= 4'h0;
			a_ext_q     <= 4'h0;
			a_pir_q     <= 4'h0;
		end else begin
			a_start_q   <= g_start;
			a_logout_q  <= g_logout;
			a_stop_q    <= g_stop;
			a_iolog_q   <= g_iolog;
			a_iostart_q <= g_iostart;
			a_iostop_q  <= g_iostop;
			a_iointr_q  <= g_iointr;
			a_ext_q     <= g_ext;
			a_pir_q     <= g_pir;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q  <= CTRL_RST;
			save_q  <= SAVE_RST;
			rdata_q <= 32'h00000000;
		end else begin
			if (wr && paddr == OFF_CTRL) begin
				ctrl_q <= ctrl_t'(pwdata);
			end
			if (wr && paddr == OFF_SAVE) begin
				save_q <= pwdata[23:0];
			end
			if (psel && !penable) begin
				case (paddr)
					OFF_CTRL: rdata_q <= ctrl_q;
					OFF_SAVE: rdata_q <= {8'h00, save_q};
					OFF_RDD:  rdata_q <= {22'h000000, rd_src_q, rd_byte_q};
					OFF_STAT: rdata_q <= stat_q;
					default:  rdata_q <= 32'h00000000;
				endcase
			end
		end
	end

	// Outgoing lines are held several cycles so an asynchronous peer sees them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_q       <= '0;
			line_cnt_q <= 3'h0;
			dout_q     <= 8'h00;
			hold_q     <= 1'b0;
		end else if (wrd_go) begin
			line_cnt_q <= 3'(LINE_CYC);
			for (int t = 0; t < 4; t++) begin
				tx_q[t] <= tgt[t] ? pulse : '0;
			end
			if (cmd == CMD_DATA) begin
				dout_q <= pwdata[15:8];
				hold_q <= 1'b1;
			end
		end else if (io_go) begin
			line_cnt_q <= 3'(LINE_CYC);
			tx_q       <= '0;
			tx_q[ctrl_q.ctl_ce].proc_intr <= 1'b1;
		end else if (ack_go) begin
			line_cnt_q <= 3'(LINE_CYC);
			tx_q       <= '0;
			tx_q[rd_src_q].rdd_ack <= 1'b1;
		end else if (!line_free) begin
			line_cnt_q <= line_cnt_q - 3'h1;
			if (line_cnt_q == 3'h1) begin
				tx_q   <= '0;
				hold_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_busy_q <= 1'b0;
			rd_src_q  <= 2'h0;
			rd_cnt_q  <= 8'h00;
			rd_byte_q <= 8'h00;
		end else if (rdd_go) begin
			rd_busy_q <= 1'b1;
			rd_src_q  <= sel_idx;
			rd_cnt_q  <= 8'h00;
		end else if (ack_go) begin
			rd_busy_q <= 1'b0;
			rd_byte_q <= byte_s_q[rd_src_q];
		end else if (tmo_hit) begin
			rd_busy_q <= 1'b0;
		end else if (rd_busy_q && hold_s_q[rd_src_q]) begin
			rd_cnt_q <= rd_cnt_q + 8'h01;
		end
	end

	// Hardware set wins over a software clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= '0;
		end else begin
			if (wr && paddr == OFF_STAT) begin
				stat_q.spec     <= stat_q.spec & ~pwdata[0];
				stat_q.priv     <= stat_q.priv & ~pwdata[1];
				stat_q.mchk     <= stat_q.mchk & ~pwdata[2];
				stat_q.tmo_id   <= stat_q.tmo_id & ~pwdata[3];
				stat_q.rdd_done <= stat_q.rdd_done & ~pwdata[4];
				stat_q.ext_intr <= stat_q.ext_intr & ~pwdata[8:5];
				stat_q.processor_intr_reg      <= stat_q.processor_intr_reg & ~pwdata[12:9];
			end
			if (reset_q) begin
				stat_q.ext_intr <= 4'h0;
				stat_q.processor_intr_reg      <= 4'h0;
			end
			if ((wr_wrd || wr_rdd) && !ctrl_q.supervisor) begin
				stat_q.priv <= 1'b1;
			end
			if ((wr_wrd && ctrl_q.supervisor && bad_cmd) || (wr_io && !io_go)
				|| (wr_rdd && ctrl_q.supervisor && !rdd_go)) begin
				stat_q.spec <= 1'b1;
			end
			if (tmo_hit) begin
				stat_q.mchk   <= 1'b1;
				stat_q.tmo_id <= 1'b1;
			end
			if (ack_go) begin
				stat_q.rdd_done <= 1'b1;
			end
			stat_q.ext_intr <= (reset_q ? 4'h0 : stat_q.ext_intr
				& ~((wr && paddr == OFF_STAT) ? pwdata[8:5] : 4'h0)) | a_ext_q;
			stat_q.processor_intr_reg <= (reset_q ? 4'h0 : stat_q.processor_intr_reg
				& ~((wr && paddr == OFF_STAT) ? pwdata[12:9] : 4'h0)) | a_pir_q;
			stat_q.rdd_busy <= rd_busy_q;
			stat_q.ce_st    <= ce_state_q;
			stat_q.io_st    <= io_state_q;
			stat_q.io_pend  <= (stat_q.io_pend && !io_take_q) || |a_iointr_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ce_state_q    <= CE_STOP;
			stop_pend_q   <= 1'b0;
			start_q       <= 1'b0;
			logout_q      <= 1'b0;
			reset_q       <= 1'b0;
			ext_take_q    <= 1'b0;
			fetch_q       <= SAVE_RST;
			logout_addr_q <= SAVE_RST;
		end else begin
			start_q    <= |a_start_q;
			logout_q   <= |a_logout_q;
			reset_q    <= 1'b0;
			ext_take_q <= instr_end && ctrl_q.ce_mask7 && ce_state_q == CE_OPER
				&& (|stat_q.ext_intr || |stat_q.processor_intr_reg);
			if (|a_logout_q) begin
				logout_addr_q <= save_q;
			end
			if (|a_stop_q) begin
				stop_pend_q <= 1'b1;
			end
			if (stop_pend_q && (instr_end || ce_state_q != CE_OPER)) begin
				stop_pend_q <= 1'b0;
				reset_q     <= 1'b1;
				ce_state_q  <= CE_STOP;
			end else if (|a_start_q) begin
				fetch_q    <= save_q;
				ce_state_q <= CE_OPER;
			end else if (check_stop) begin
				ce_state_q <= CE_CHKSTOP;
			end else if (ce_state_q == CE_OPER && core_wait) begin
				ce_state_q <= CE_WAIT;
			end else if (ce_state_q == CE_WAIT && !core_wait) begin
				ce_state_q <= CE_OPER;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io_state_q     <= IO_STOP;
			io_stop_pend_q <= 1'b0;
			io_fetch_q     <= 1'b0;
			io_take_q      <= 1'b0;
			io_log_q       <= 1'b0;
			io_logout_src  <= 4'h0;
		end else begin
			io_fetch_q <= 1'b0;
			io_take_q  <= stat_q.io_pend && !io_take_q && ctrl_q.io_mask7
				&& io_state_q != IO_STOP;
			io_log_q   <= |a_iolog_q;
			if (|a_iolog_q) begin
				io_logout_src <= a_iolog_q;
			end
			if (|a_iostop_q && io_state_q != IO_STOP) begin
				io_stop_pend_q <= 1'b1;
			end
			unique case (io_state_q)
				IO_STOP: if (|a_iostart_q) begin
					io_state_q     <= ctrl_q.io_wait ? IO_WAIT : IO_RUN;
					io_fetch_q     <= !ctrl_q.io_wait;
					io_stop_pend_q <= 1'b0;
				end
				IO_RUN, IO_WAIT: if (io_stop_pend_q
					&& (io_instr_end || io_state_q == IO_WAIT)) begin
					io_state_q     <= IO_STOP;
					io_stop_pend_q <= 1'b0;
				end
			endcase
		end
	end

	assign tx_line       = tx_q;
	assign direct_out    = dout_q;
	assign hold_out      = hold_q;
	assign ce_state      = ce_state_q;
	assign io_state      = io_state_q;
	assign start_fetch   = start_q;
	assign fetch_addr    = fetch_q;
	assign logout_req    = logout_q;
	assign logout_addr   = logout_addr_q;
	assign ce_reset      = reset_q;
	assign ext_take      = ext_take_q;
	assign io_fetch      = io_fetch_q;
	assign io_take       = io_take_q;
	assign io_timer_en   = (io_state_q != IO_STOP);
	assign io_logout_req = io_log_q;

	onehot_cmd_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wrd_go && cmd != CMD_DATA) |=> $onehot(tx_nz)) else $error("multi target");
	priv_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_wrd && !ctrl_q.supervisor) |=> stat_q.priv && $stable(tx_q))
		else $error("write direct outside supervisor");
	start_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
		(|a_start_q && !stop_pend_q) |=> start_q && fetch_q == $past(save_q)
		&& ce_state_q == CE_OPER) else $error("start fetch wrong");
	stop_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
		(stop_pend_q && instr_end) |=> reset_q && ce_state_q == CE_STOP ##1
		stat_q.ext_intr == $past(a_ext_q)) else $error("stop not taken");
	io_start_a: assert property (@(posedge pclk) disable iff (!presetn)
		(|a_iostart_q && io_state_q == IO_STOP && !ctrl_q.io_wait)
		|=> io_state_q == IO_RUN && io_fetch_q) else $error("io start wrong");
	io_take_a: assert property (@(posedge pclk) disable iff (!presetn)
		io_take_q |-> $past(ctrl_q.io_mask7) && $past(io_state_q) != IO_STOP)
		else $error("io interrupt taken while masked");
	rdd_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
		ack_go |=> tx_q[$past(rd_src_q)].rdd_ack && !rd_busy_q
		&& rd_byte_q == $past(byte_s_q[rd_src_q])) else $error("read direct ack");
	hold_tmo_a: assert property (@(posedge pclk) disable iff (!presetn)
		tmo_hit |=> !rd_busy_q && stat_q.mchk && stat_q.tmo_id && !reset_q)
		else $error("hold timeout not flagged");
	ext_take_a: assert property (@(posedge pclk) disable iff (!presetn)
		ext_take_q |-> $past(ctrl_q.ce_mask7) && $past(instr_end))
		else $error("external interrupt taken while masked");
	data_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		(a_ext_q & ~$past(ctrl_q.data_comm)) == 4'h0) else $error("excluded sender");
	dout_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!wrd_go |=> $stable(dout_q)) else $error("direct out changed");
endmodule
`default_nettype wire
